// [verilog/irq_route_pkg.sv]
// Function
// - Selector zero routes the source nowhere
// - Legal nonzero selector drives matching channel number
// - Offset 6Ch holds INTA/INTB selectors, resets 00h
// - Offset 6Dh holds INTC/INTD selectors, resets 00h
// - Offset 6Eh keyboard/pointer selectors, resets C1h
// - Offset 6Fh expansion 0/1 selectors, resets 00h
// - Routing registers are 8-bit RW in function 1
// - Each channel has edge/level select bit
package irq_route_pkg;

  // Configuration space location of the routing block
  localparam logic [2:0] ROUTE_FUNC          = 3'h1;
  localparam logic [7:0] PCI_INT_AB_OFFSET   = 8'h6c;
  localparam logic [7:0] PCI_INT_CD_OFFSET   = 8'h6d;
  localparam logic [7:0] KBD_MOUSE_OFFSET    = 8'h6e;
  localparam logic [7:0] EXPANSION_OFFSET    = 8'h6f;
  localparam logic [7:0] TRIGGER_LO_OFFSET   = 8'h66;
  localparam logic [7:0] TRIGGER_HI_OFFSET   = 8'h67;

  // Reset values
  localparam logic [7:0] PCI_INT_AB_RESET    = 8'h00;
  localparam logic [7:0] PCI_INT_CD_RESET    = 8'h00;
  localparam logic [7:0] KBD_MOUSE_RESET     = 8'hc1;
  localparam logic [7:0] EXPANSION_RESET     = 8'h00;
  localparam logic [7:0] TRIGGER_RESET       = 8'h00;

  // Selector field layout inside each routing byte
  localparam int         SEL_WIDTH           = 4;
  localparam int         LOW_SEL_LSB         = 0;
  localparam int         HIGH_SEL_LSB        = 4;

  // Selector codes with no defined route
  localparam logic [3:0] SEL_NONE            = 4'h0;
  localparam logic [3:0] SEL_RSVD_A          = 4'h2;
  localparam logic [3:0] SEL_RSVD_B          = 4'h8;
  localparam logic [3:0] SEL_RSVD_C          = 4'hd;

  // Channel count of the cascaded controller pair
  localparam int         NUM_CHANNELS        = 16;
  localparam int         NUM_SOURCES         = 8;

  // Source order on the routing bus
  localparam int         SRC_INTA            = 0;
  localparam int         SRC_INTB            = 1;
  localparam int         SRC_INTC            = 2;
  localparam int         SRC_INTD            = 3;
  localparam int         SRC_KBD             = 4;
  localparam int         SRC_MOUSE           = 5;
  localparam int         SRC_EXP0            = 6;
  localparam int         SRC_EXP1            = 7;

  // A selector code that maps to a real channel
  function automatic logic sel_is_routed(input logic [3:0] sel);
    sel_is_routed = (sel != SEL_NONE) && (sel != SEL_RSVD_A) &&
                    (sel != SEL_RSVD_B) && (sel != SEL_RSVD_C);
  endfunction : sel_is_routed

endpackage : irq_route_pkg

// [verilog/irq_route_decode.sv]
`timescale 1ns/1ps
// One source steered onto the channel vector by its selector
module irq_route_decode
  import irq_route_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input  wire logic [3:0]          sel,
  input  wire logic                request,
  output logic      [CHANNELS-1:0] channel_hit
);

  if (CHANNELS != 16) begin : g_bad_channels
    $error("irq_route_decode needs 16 channels");
  end

  // Zero and reserved codes drive nothing; legal code n drives channel n
  always_comb begin
    channel_hit = '0;
    if (request && sel_is_routed(sel)) begin
      channel_hit[sel] = 1'b1;
    end
  end

endmodule : irq_route_decode

// [verilog/irq_source_routing_matrix.sv]
`timescale 1ns/1ps
// Routing matrix: eight interrupt sources onto sixteen controller channels.
// Configuration accesses arrive as byte cycles already decoded to this device;
// the function number is checked here so only function 1 reaches the registers.
module irq_source_routing_matrix
  import irq_route_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  // Configuration cycle port
  input  wire logic                cfg_wr,
  input  wire logic                cfg_rd,
  input  wire logic [2:0]          cfg_func,
  input  wire logic [7:0]          cfg_offset,
  input  wire logic [7:0]          cfg_wdata,
  output logic      [7:0]          cfg_rdata,
  output logic                     cfg_rd_ack,
  // Interrupt sources
  input  wire logic [3:0]          pci_int_n,
  input  wire logic                keyboard_request,
  input  wire logic                pointer_request,
  input  wire logic                expansion_request_0,
  input  wire logic                expansion_request_1,
  // Controller side
  output logic      [CHANNELS-1:0] channel_request,
  output logic      [CHANNELS-1:0] channel_level_sel
);

  if (CHANNELS != 16) begin : g_bad_channels
    $error("irq_source_routing_matrix needs 16 channels");
  end

  // The selector block below is wired for two 4-bit nibbles per byte and
  // eight sources; any other package layout would silently misroute
  if (SEL_WIDTH != 4) begin : g_bad_width
    $error("irq_source_routing_matrix needs 4-bit selectors");
  end
  if (LOW_SEL_LSB != 0 || HIGH_SEL_LSB != 4) begin : g_bad_nibbles
    $error("irq_source_routing_matrix needs selectors at bits 3:0 and 7:4");
  end
  if (NUM_SOURCES != 8) begin : g_bad_sources
    $error("irq_source_routing_matrix routes exactly eight sources");
  end

  // Register addressed by a configuration cycle; REG_NONE also covers
  // cycles meant for another function of the device
  typedef enum {
    REG_NONE,
    REG_INT_AB,
    REG_INT_CD,
    REG_KBD_MOUSE,
    REG_EXPANSION,
    REG_TRIGGER_LO,
    REG_TRIGGER_HI
  } reg_sel_t;

  // One map shared by the write and read paths, so the two can never
  // disagree about which byte an offset names
  function automatic reg_sel_t decode_offset(input logic [2:0] func,
                                             input logic [7:0] offset);
    reg_sel_t sel;
    sel = REG_NONE;
    if (func == ROUTE_FUNC) begin
      unique case (offset)
        PCI_INT_AB_OFFSET: sel = REG_INT_AB;
        PCI_INT_CD_OFFSET: sel = REG_INT_CD;
        KBD_MOUSE_OFFSET:  sel = REG_KBD_MOUSE;
        EXPANSION_OFFSET:  sel = REG_EXPANSION;
        TRIGGER_LO_OFFSET: sel = REG_TRIGGER_LO;
        TRIGGER_HI_OFFSET: sel = REG_TRIGGER_HI;
        default:           sel = REG_NONE; // Left for other responders
      endcase
    end
    return sel;
  endfunction : decode_offset

  // All state of the block
  // Outputs are fields here too, so every pin leaves a flip-flop
  typedef struct packed {
    logic [7:0]          pci_int_ab_route;
    logic [7:0]          pci_int_cd_route;
    logic [7:0]          kbd_mouse_route;
    logic [7:0]          expansion_irq01_route;
    logic [CHANNELS-1:0] level_sel;
    logic [CHANNELS-1:0] chan_req;
    logic [7:0]          rdata;
    logic                rd_ack;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [NUM_SOURCES-1:0]   src_req;
  logic [3:0]               src_sel [NUM_SOURCES];
  logic [CHANNELS-1:0]      src_hit [NUM_SOURCES];
  logic [CHANNELS-1:0]      merged_req;
  reg_sel_t                 access_sel;

  // PCI lines are active low; invert before they meet the matrix
  always_comb begin
    src_req[SRC_INTA]  = ~pci_int_n[0];
    src_req[SRC_INTB]  = ~pci_int_n[1];
    src_req[SRC_INTC]  = ~pci_int_n[2];
    src_req[SRC_INTD]  = ~pci_int_n[3];
    // The remaining sources already arrive active high
    src_req[SRC_KBD]   = keyboard_request;
    src_req[SRC_MOUSE] = pointer_request;
    src_req[SRC_EXP0]  = expansion_request_0;
    src_req[SRC_EXP1]  = expansion_request_1;
  end

  // Selector nibbles as laid out in the routing bytes
  always_comb begin
    src_sel[SRC_INTA]  = state_reg.pci_int_ab_route[LOW_SEL_LSB +: SEL_WIDTH];
    src_sel[SRC_INTB]  = state_reg.pci_int_ab_route[HIGH_SEL_LSB +: SEL_WIDTH];
    src_sel[SRC_INTC]  = state_reg.pci_int_cd_route[LOW_SEL_LSB +: SEL_WIDTH];
    src_sel[SRC_INTD]  = state_reg.pci_int_cd_route[HIGH_SEL_LSB +: SEL_WIDTH];
    src_sel[SRC_KBD]   = state_reg.kbd_mouse_route[LOW_SEL_LSB +: SEL_WIDTH];
    src_sel[SRC_MOUSE] = state_reg.kbd_mouse_route[HIGH_SEL_LSB +: SEL_WIDTH];
    src_sel[SRC_EXP0]  = state_reg.expansion_irq01_route[LOW_SEL_LSB +: SEL_WIDTH];
    src_sel[SRC_EXP1]  = state_reg.expansion_irq01_route[HIGH_SEL_LSB +: SEL_WIDTH];
  end

  // One decoder per source
  // Each decoder sets at most one channel bit; zero and reserved codes none
  for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_src
    irq_route_decode #(
      .CHANNELS    (CHANNELS)
    ) u_decode (
      .sel         (src_sel[s]),
      .request     (src_req[s]),
      .channel_hit (src_hit[s])
    );
  end

  // Sources that share a channel are wire-ORed, as on a shared IRQ line
  // A source routed nowhere adds no bits, so it cannot mask a neighbour
  always_comb begin
    merged_req = '0;
    for (int s = 0; s < NUM_SOURCES; s++) begin
      merged_req = merged_req | src_hit[s];
    end
  end

  // Only function 1 cycles at mapped offsets are ours; the rest answer elsewhere
  assign access_sel = decode_offset(cfg_func, cfg_offset);

  // Register writes, read answer and registered channel outputs
  always_comb begin
    state_next          = state_reg;
    state_next.chan_req = merged_req;
    state_next.rd_ack   = 1'b0;
    state_next.rdata    = '0;
    // Byte writes; cycles for other functions or unmapped offsets are dropped
    if (cfg_wr) begin
      unique case (access_sel)
        REG_INT_AB:     state_next.pci_int_ab_route      = cfg_wdata;
        REG_INT_CD:     state_next.pci_int_cd_route      = cfg_wdata;
        REG_KBD_MOUSE:  state_next.kbd_mouse_route       = cfg_wdata;
        REG_EXPANSION:  state_next.expansion_irq01_route = cfg_wdata;
        REG_TRIGGER_LO: state_next.level_sel[7:0]        = cfg_wdata;
        REG_TRIGGER_HI: state_next.level_sel[15:8]       = cfg_wdata;
        REG_NONE:       ;
      endcase
    end
    // A read returns the value held before a same-cycle write
    // Unmapped reads leave the ack low so another responder may claim the cycle
    if (cfg_rd) begin
      unique case (access_sel)
        REG_INT_AB: begin
          state_next.rdata  = state_reg.pci_int_ab_route;
          state_next.rd_ack = 1'b1;
        end
        REG_INT_CD: begin
          state_next.rdata  = state_reg.pci_int_cd_route;
          state_next.rd_ack = 1'b1;
        end
        REG_KBD_MOUSE: begin
          state_next.rdata  = state_reg.kbd_mouse_route;
          state_next.rd_ack = 1'b1;
        end
        REG_EXPANSION: begin
          state_next.rdata  = state_reg.expansion_irq01_route;
          state_next.rd_ack = 1'b1;
        end
        REG_TRIGGER_LO: begin
          state_next.rdata  = state_reg.level_sel[7:0];
          state_next.rd_ack = 1'b1;
        end
        REG_TRIGGER_HI: begin
          state_next.rdata  = state_reg.level_sel[15:8];
          state_next.rd_ack = 1'b1;
        end
        REG_NONE: ; // No answer, so another responder can claim it
      endcase
    end
  end

  // Defaults load at reset; keyboard on channel 1, pointer on 12
  // The reset branch loads constants only, never a live input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.pci_int_ab_route      <= PCI_INT_AB_RESET;
      state_reg.pci_int_cd_route      <= PCI_INT_CD_RESET;
      state_reg.kbd_mouse_route       <= KBD_MOUSE_RESET;
      state_reg.expansion_irq01_route <= EXPANSION_RESET;
      // Every channel starts edge sensed
      state_reg.level_sel             <= {TRIGGER_RESET, TRIGGER_RESET};
      state_reg.chan_req              <= '0;
      state_reg.rdata                 <= '0;
      state_reg.rd_ack                <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops; one cycle of latency is the price
  // A source change reaches the controller one edge later
  assign channel_request   = state_reg.chan_req;
  assign channel_level_sel = state_reg.level_sel;
  assign cfg_rdata         = state_reg.rdata;
  assign cfg_rd_ack        = state_reg.rd_ack;

endmodule : irq_source_routing_matrix

// [testbench/irq_route_chk.sv]
`timescale 1ns/1ps
// Watches the routing matrix from its pins only
module irq_route_chk #(
  parameter int CHANNELS = 16
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                cfg_rd,
  input wire logic [2:0]          cfg_func,
  input wire logic [7:0]          cfg_offset,
  input wire logic [7:0]          cfg_rdata,
  input wire logic                cfg_rd_ack,
  input wire logic [3:0]          pci_int_n,
  input wire logic                keyboard_request,
  input wire logic                pointer_request,
  input wire logic                expansion_request_0,
  input wire logic                expansion_request_1,
  input wire logic [CHANNELS-1:0] channel_request,
  input wire logic [CHANNELS-1:0] channel_level_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Config answers: one edge late, only for function 1, data bus quiet otherwise
  a_rd_ack_next: assert property (
    cfg_rd && cfg_func == 3'h1 && cfg_offset[7:2] == 6'h1b |=> cfg_rd_ack) else $error("no ack");
  a_func_refused: assert property (cfg_rd && cfg_func != 3'h1 |=> !cfg_rd_ack)
    else $error("foreign function acknowledged");
  a_ack_cause: assert property (cfg_rd_ack |-> $past(cfg_rd) && $past(cfg_func) == 3'h1)
    else $error("ack without read");
  a_rdata_quiet: assert property (!cfg_rd_ack |-> cfg_rdata == 8'h00)
    else $error("read data outside ack");
  // Routing: idle sources give idle channels; unroutable channels never fire
  a_idle_quiet: assert property (
    &pci_int_n && !keyboard_request && !pointer_request && !expansion_request_0 &&
    !expansion_request_1 |=> channel_request == '0) else $error("request with idle sources");
  a_no_reserved: assert property ((channel_request & 16'h2105) == 16'h0000)
    else $error("unroutable channel driven");
  a_kbd_default: assert property ($rose(rstn) && keyboard_request |=> channel_request[1])
    else $error("keyboard default route lost");
  a_sense_reset: assert property ($rose(rstn) |-> channel_level_sel == '0)
    else $error("sense select not cleared");
endmodule : irq_route_chk
bind irq_source_routing_matrix irq_route_chk #(.CHANNELS(CHANNELS)) u_chk (.clk(clk), .rstn(rstn),
  .cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_offset(cfg_offset), .cfg_rdata(cfg_rdata),
  .cfg_rd_ack(cfg_rd_ack), .pci_int_n(pci_int_n), .keyboard_request(keyboard_request),
  .pointer_request(pointer_request), .expansion_request_0(expansion_request_0),
  .expansion_request_1(expansion_request_1), .channel_request(channel_request),
  .channel_level_sel(channel_level_sel));

// [testbench/pic_input_model.sv]
`timescale 1ns/1ps
// Controller input stage: edge channels latch a rise, level channels follow the line
module pic_input_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] channel_request,
  input  wire logic [15:0] channel_level_sel,
  output logic      [15:0] pending
);
  logic [15:0] last_reg;
  // No acknowledge cycle here, so latched edges stay pending until reset or until the channel is switched to level sensing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_reg <= 16'h0000;
      pending  <= 16'h0000;
    end else begin
      last_reg <= channel_request;
      pending  <= (channel_level_sel & channel_request) |
                  (~channel_level_sel & (pending | (channel_request & ~last_reg)));
    end
  end
endmodule : pic_input_model

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rstn = 0, cfg_wr = 0, cfg_rd = 0, cfg_rd_ack;
  logic [2:0]  cfg_func = 3'h1;
  logic [7:0]  cfg_offset = 8'h00, cfg_wdata = 8'h00, cfg_rdata, src = 8'h00;
  logic [7:0]  rt [4];
  logic [15:0] channel_request, channel_level_sel, pending;
  logic [31:0] seed = 32'h7f1a;
  int          miscompares = 0, n_checks = 0;
  always #5 clk = ~clk;
  // Sources held as active-high bits; the PCI lines go in inverted
  irq_source_routing_matrix DUT (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_func(cfg_func), .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_ack(cfg_rd_ack), .pci_int_n(~src[3:0]), .keyboard_request(src[4]),
    .pointer_request(src[5]), .expansion_request_0(src[6]), .expansion_request_1(src[7]),
    .channel_request(channel_request), .channel_level_sel(channel_level_sel));
  pic_input_model PIC (.clk(clk), .rstn(rstn), .channel_request(channel_request),
    .channel_level_sel(channel_level_sel), .pending(pending));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Software keeps off the undefined codes, so they are folded to no route
  function automatic logic [3:0] legal(input logic [3:0] c);
    return (c == 4'h2 || c == 4'h8 || c == 4'hd) ? 4'h0 : c;
  endfunction : legal
  function automatic logic [15:0] route(input logic [7:0] s);
    logic [3:0] c;
    route = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      c = rt[i / 2][4 * (i % 2) +: 4];
      if (s[i] && c != 4'h0) route[c] = 1'b1;
    end
  endfunction : route
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk
  // One byte cycle; a read is judged on the ack edge, where ack and data stand
  task automatic acc(input logic w, input logic [2:0] f, input logic [7:0] o, d, input logic a);
    @(posedge clk);
    {cfg_wr, cfg_rd, cfg_func, cfg_offset, cfg_wdata} <= {w, !w, f, o, d};
    @(posedge clk);
    {cfg_wr, cfg_rd} <= 2'b00;
    #1;
    if (!w) chk("read ack", {15'h0, a}, {15'h0, cfg_rd_ack});
    if (!w) chk("read data", {8'h00, a ? d : 8'h00}, {8'h00, cfg_rdata});
  endtask : acc
  task automatic drive(input logic [7:0] s);
    @(posedge clk);
    src <= s;
    @(posedge clk);
    #1;
    chk("channel requests", route(s), channel_request);
  endtask : drive
  task automatic reset();
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rt = '{8'h00, 8'h00, 8'hc1, 8'h00};
  endtask : reset
  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    reset();
    for (int i = 0; i < 4; i++) acc(0, 3'h1, 8'h6c + 8'(i), rt[i], 1);
    drive(8'h30);
    for (int n = 0; n < 60; n++) begin
      for (int i = 0; i < 4; i++) begin
        rt[i] = {legal(4'(rnd())), legal(4'(rnd()))};
        acc(1, 3'h1, 8'h6c + 8'(i), rt[i], 0);
        acc(0, 3'h1, 8'h6c + 8'(i), rt[i], 1);
      end
      drive(8'(rnd()));
      drive(8'hff);
    end
    // Refused cycles, then the trigger bytes; 22h never matches a stored byte, so a landed write shows
    acc(0, 3'h0, 8'h6e, 8'h00, 0);
    acc(1, 3'h2, 8'h6e, 8'h22, 0);
    acc(0, 3'h1, 8'h70, 8'h00, 0);
    acc(0, 3'h1, 8'h6e, rt[2], 1);
    acc(1, 3'h1, 8'h66, 8'ha5, 0);
    acc(1, 3'h1, 8'h67, 8'h3c, 0);
    acc(0, 3'h1, 8'h66, 8'ha5, 1);
    acc(0, 3'h1, 8'h67, 8'h3c, 1);
    @(posedge clk);
    #1;
    chk("sense select", 16'h3ca5, channel_level_sel);
    // Level channels follow the line; every source still stands from the last drive
    chk("level pending", route(8'hff) & 16'h3ca5, pending & 16'h3ca5);
    // Mid-run reset with all sources up: defaults return and route keyboard and pointer
    reset();
    for (int i = 0; i < 4; i++) acc(0, 3'h1, 8'h6c + 8'(i), rt[i], 1);
    chk("sense select", 16'h0000, channel_level_sel);
    drive(8'h10);
    @(posedge clk);
    #1;
    // Edge channels keep the rises on 1 and 12 seen just after the reset
    chk("edge pending", 16'h1002, pending);
    final_report();
  end
endmodule : tb
